/* File: logic/reset_source_controller_map.vh */
// register offsets, field positions, reset values and timing counts of the
// reset source controller; definitions only
`ifndef RESET_SOURCE_CONTROLLER_MAP_VH
`define RESET_SOURCE_CONTROLLER_MAP_VH

`define RSC_ADDR_CAUSE 8'hef
`define RSC_ADDR_SUPPLY 8'hff
`define RSC_ADDR_WATCHDOG 8'hd8

// reset_cause_and_enable fields
`define RSC_BIT_RTC 7
`define RSC_BIT_FLASH 6
`define RSC_BIT_CMP 5
`define RSC_BIT_SOFT 4
`define RSC_BIT_WDOG 3
`define RSC_BIT_CLK 2
`define RSC_BIT_POWER 1
`define RSC_BIT_PIN 0
`define RSC_CAUSE_POR 8'h02

// supply_monitor_control fields
`define RSC_BIT_SUP_ON 7
`define RSC_BIT_SUP_ABOVE 6
`define RSC_BIT_SUP_HIGH 5

// watchdog control fields
`define RSC_BIT_WD_EN 6
`define RSC_BIT_WD_KICK 0
`define RSC_WD_DIV 4'd12
`define RSC_WD_LIMIT 16'hffff

// timing
`define RSC_CORE_CLK_MHZ 12'h014
`define RSC_CLK_LOSS_TIME_US 12'h064
`define RSC_CLK_LOSS_CYCLES (`RSC_CLK_LOSS_TIME_US * `RSC_CORE_CLK_MHZ)
`define RSC_RELEASE_CYCLES 5'd16

`endif

/* File: logic/rsc_sync2.v */
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module rsc_sync2 #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);
   reg [W-1:0] meta_r;
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_r <= INIT;
         o_sync <= INIT;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: logic/rsc_clock_loss.v */
// clock loss detector: times a monitored clock level that stops toggling
// assumes the monitored level is already synchronised to the core clock
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_controller_map.vh"
module rsc_clock_loss (
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire i_enable,
   input wire i_level,
   output reg o_timeout
);
   localparam [11:0] LIMIT = `RSC_CLK_LOSS_CYCLES;
   reg last_r;
   reg [11:0] count_r;
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         last_r <= 1'b0;
         count_r <= 12'h000;
         o_timeout <= 1'b0;
      end else begin
         last_r <= i_level;
         o_timeout <= 1'b0;
         if (!i_enable || (i_level != last_r)) begin
            count_r <= 12'h000;
         end else if (count_r >= LIMIT - 12'h001) begin
            count_r <= 12'h000;
            o_timeout <= 1'b1;
         end else begin
            count_r <= count_r + 12'h001;
         end
      end
   end
endmodule
`default_nettype wire

/* File: logic/reset_source_controller.v */
// reset source controller: gathers reset requests, holds the system reset,
// records the cause and hosts the supply monitor and watchdog controls
// assumes i_sys_rst is the power-on reset
//
// Operation
// - supply monitor on bit 7, on after power-on; resets only when selected
// - bit 6 shows the live supply monitor output
// - bit 5 selects low (0) or high (1) threshold
// - supply control bits 4-0 ignore writes; read as zero
// - low reset pin resets the device and sets pin flag bit 0
// - enabled clock detector resets after 100 us without a clock edge
// - bit 2 write enables clock detector; read shows clock loss cause
// - only power-on and supply resets drive the reset pin low
// - comparator enabled by bit 5 resets when plus input below minus
// - watchdog on after any reset, clocked at core clock over 12
// - flash faults or writes with monitor off reset and set bit 6
// - rtc enabled by bit 7 resets on alarm or oscillator fail
// - writing 1 to bit 4 forces a reset; 0 does nothing
// - read-modify-write reads return stored enables, not cause flags
// - bit 1 marks power-on or supply reset; write selects supply monitor
// - monitor on state survives every reset except power-on
// - every other reset clears the power-on flag
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_controller_map.vh"
module reset_source_controller #(
   parameter [15:0] WD_LIMIT = `RSC_WD_LIMIT
) (
   input wire i_core_clk,
   input wire i_sys_rst,
   input wire [7:0] i_addr,
   input wire [7:0] i_wr_data,
   input wire i_wr,
   input wire i_rd,
   input wire i_rd_rmw,
   output reg [7:0] o_rd_data,
   input wire i_rst_pin_n,
   output reg o_rst_pin_out,
   output reg o_rst_pin_oe,
   input wire i_supply_above,
   input wire i_cmp_below,
   input wire i_rtc_alarm,
   input wire i_rtc_osc_fail,
   input wire i_clk_probe,
   input wire i_flash_fault,
   input wire i_flash_program,
   output reg o_sys_reset,
   output reg o_supply_on,
   output reg o_supply_high
);
   localparam ST_RUN = 1'b0;
   localparam ST_HOLD = 1'b1;

   wire [5:0] sync_w;
   wire pin_n_s;
   wire above_s;
   wire cmp_below_s;
   wire rtc_alarm_s;
   wire rtc_fail_s;
   wire probe_s;
   wire clk_loss_w;
   wire pin_low_w;
   wire supply_low_w;

   reg state_r;
   reg [4:0] hold_r;
   reg [7:0] cause_r;
   reg sup_sel_r;
   reg clk_en_r;
   reg cmp_en_r;
   reg rtc_en_r;
   reg soft_req_r;
   reg wd_en_r;
   reg [3:0] wd_div_r;
   reg [15:0] wd_cnt_r;
   reg wd_fire_r;
   reg [7:0] req_nxt;
   reg [7:0] rd_nxt;
   reg [1:0] oe_dly_r;

   // pin and analog levels enter through two flip-flops
   rsc_sync2 #(
      .W(6),
      .INIT(6'h03)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_clk_probe, i_rtc_osc_fail, i_rtc_alarm,
                i_cmp_below, i_supply_above,
                i_rst_pin_n}),
      .o_sync(sync_w)
   );
   assign pin_n_s = sync_w[0];
   assign above_s = sync_w[1];
   assign cmp_below_s = sync_w[2];
   assign rtc_alarm_s = sync_w[3];
   assign rtc_fail_s = sync_w[4];
   assign probe_s = sync_w[5];

   // request levels shared by the run and hold states
   assign supply_low_w = o_supply_on && sup_sel_r && !above_s;
   assign pin_low_w = !pin_n_s && !o_rst_pin_oe && (oe_dly_r == 2'h0);

   // own pin drive reads back low for two more edges; keep it from looking like a pin reset
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         oe_dly_r <= 2'h3;
      end else begin
         oe_dly_r <= {oe_dly_r[0], o_rst_pin_oe};
      end
   end

   rsc_clock_loss u_clk_loss (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_enable(clk_en_r && (state_r == ST_RUN)),
      .i_level(probe_s),
      .o_timeout(clk_loss_w)
   );

   // register decode, used by both write and read paths
   function is_addr;
      input [7:0] a;
      input [7:0] b;
      begin
         is_addr = (a == b);
      end
   endfunction

   // pending reset requests, one bit per cause position
   always @* begin
      req_nxt = 8'h00;
      req_nxt[`RSC_BIT_POWER] = supply_low_w;
      req_nxt[`RSC_BIT_PIN] = pin_low_w;
      req_nxt[`RSC_BIT_CLK] = clk_loss_w;
      req_nxt[`RSC_BIT_WDOG] = wd_fire_r;
      req_nxt[`RSC_BIT_FLASH] = i_flash_fault || (i_flash_program && !o_supply_on);
      req_nxt[`RSC_BIT_CMP] = cmp_en_r && cmp_below_s;
      req_nxt[`RSC_BIT_RTC] = rtc_en_r && (rtc_alarm_s || rtc_fail_s);
      req_nxt[`RSC_BIT_SOFT] = soft_req_r;
   end

   // reset sequencer and cause capture
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_r <= ST_HOLD;
         hold_r <= `RSC_RELEASE_CYCLES;
         cause_r <= `RSC_CAUSE_POR;
         o_sys_reset <= 1'b1;
         o_rst_pin_oe <= 1'b1;
         o_rst_pin_out <= 1'b0;
      end else begin
         o_rst_pin_out <= 1'b0;
         case (state_r)
            ST_RUN: begin
               if (req_nxt != 8'h00) begin
                  state_r <= ST_HOLD;
                  hold_r <= `RSC_RELEASE_CYCLES;
                  o_sys_reset <= 1'b1;
                  // one cause recorded; power-on flag cleared by others
                  if (req_nxt[`RSC_BIT_POWER]) begin
                     cause_r <= `RSC_CAUSE_POR;
                     o_rst_pin_oe <= 1'b1;
                  end else if (req_nxt[`RSC_BIT_PIN]) begin
                     cause_r <= 8'h01 << `RSC_BIT_PIN;
                  end else if (req_nxt[`RSC_BIT_CLK]) begin
                     cause_r <= 8'h01 << `RSC_BIT_CLK;
                  end else if (req_nxt[`RSC_BIT_WDOG]) begin
                     cause_r <= 8'h01 << `RSC_BIT_WDOG;
                  end else if (req_nxt[`RSC_BIT_FLASH]) begin
                     cause_r <= 8'h01 << `RSC_BIT_FLASH;
                  end else if (req_nxt[`RSC_BIT_CMP]) begin
                     cause_r <= 8'h01 << `RSC_BIT_CMP;
                  end else if (req_nxt[`RSC_BIT_RTC]) begin
                     cause_r <= 8'h01 << `RSC_BIT_RTC;
                  end else begin
                     cause_r <= 8'h01 << `RSC_BIT_SOFT;
                  end
               end
            end
            ST_HOLD: begin
               // pin low or supply low keeps the device in reset; own drive ignored
               if (pin_low_w || supply_low_w) begin
                  hold_r <= `RSC_RELEASE_CYCLES;
               end else if (hold_r == 5'd0) begin
                  state_r <= ST_RUN;
                  o_sys_reset <= 1'b0;
                  o_rst_pin_oe <= 1'b0;
               end else begin
                  hold_r <= hold_r - 5'd1;
               end
            end
            default: begin
               state_r <= ST_HOLD;
               hold_r <= `RSC_RELEASE_CYCLES;
            end
         endcase
      end
   end

   // software registers; system reset reloads most, power-on reloads all to their reset values
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_supply_on <= 1'b1;
         sup_sel_r <= 1'b1;
         o_supply_high <= 1'b0;
         clk_en_r <= 1'b0;
         cmp_en_r <= 1'b0;
         rtc_en_r <= 1'b0;
         soft_req_r <= 1'b0;
         wd_en_r <= 1'b1;
      end else if (state_r == ST_HOLD) begin
         // monitor on and selection kept across non power-on resets
         o_supply_high <= 1'b0;
         clk_en_r <= 1'b0;
         cmp_en_r <= 1'b0;
         rtc_en_r <= 1'b0;
         soft_req_r <= 1'b0;
         wd_en_r <= 1'b1;
      end else begin
         soft_req_r <= 1'b0;
         if (i_wr && is_addr(i_addr, `RSC_ADDR_SUPPLY)) begin
            o_supply_on <= i_wr_data[`RSC_BIT_SUP_ON];
            o_supply_high <= i_wr_data[`RSC_BIT_SUP_HIGH];
         end
         if (i_wr && is_addr(i_addr, `RSC_ADDR_CAUSE)) begin
            rtc_en_r <= i_wr_data[`RSC_BIT_RTC];
            cmp_en_r <= i_wr_data[`RSC_BIT_CMP];
            clk_en_r <= i_wr_data[`RSC_BIT_CLK];
            sup_sel_r <= i_wr_data[`RSC_BIT_POWER];
            soft_req_r <= i_wr_data[`RSC_BIT_SOFT];
         end
         if (i_wr && is_addr(i_addr, `RSC_ADDR_WATCHDOG)) begin
            wd_en_r <= i_wr_data[`RSC_BIT_WD_EN];
         end
      end
   end

   // watchdog: core clock over 12, restarted by a kick write
   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wd_div_r <= 4'h0;
         wd_cnt_r <= 16'h0000;
         wd_fire_r <= 1'b0;
      end else if (state_r == ST_HOLD || !wd_en_r) begin
         wd_div_r <= 4'h0;
         wd_cnt_r <= 16'h0000;
         wd_fire_r <= 1'b0;
      end else if (i_wr && is_addr(i_addr, `RSC_ADDR_WATCHDOG)
                   && i_wr_data[`RSC_BIT_WD_KICK]) begin
         wd_div_r <= 4'h0;
         wd_cnt_r <= 16'h0000;
         wd_fire_r <= 1'b0;
      end else begin
         wd_fire_r <= 1'b0;
         if (wd_div_r == `RSC_WD_DIV - 4'h1) begin
            wd_div_r <= 4'h0;
            if (wd_cnt_r == WD_LIMIT) begin
               wd_fire_r <= 1'b1;
               wd_cnt_r <= 16'h0000;
            end else begin
               wd_cnt_r <= wd_cnt_r + 16'h0001;
            end
         end else begin
            wd_div_r <= wd_div_r + 4'h1;
         end
      end
   end

   // read mux; data stands in the cycle after the strobe
   always @* begin
      rd_nxt = 8'h00;
      if (is_addr(i_addr, `RSC_ADDR_CAUSE)) begin
         if (i_rd_rmw) begin
            rd_nxt[`RSC_BIT_RTC] = rtc_en_r;
            rd_nxt[`RSC_BIT_CMP] = cmp_en_r;
            rd_nxt[`RSC_BIT_CLK] = clk_en_r;
            rd_nxt[`RSC_BIT_POWER] = sup_sel_r;
         end else begin
            rd_nxt = cause_r;
         end
      end else if (is_addr(i_addr, `RSC_ADDR_SUPPLY)) begin
         rd_nxt[`RSC_BIT_SUP_ON] = o_supply_on;
         rd_nxt[`RSC_BIT_SUP_ABOVE] = above_s;
         rd_nxt[`RSC_BIT_SUP_HIGH] = o_supply_high;
      end else if (is_addr(i_addr, `RSC_ADDR_WATCHDOG)) begin
         rd_nxt[`RSC_BIT_WD_EN] = wd_en_r;
      end
   end

   always @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rd_data <= 8'h00;
      end else if (i_rd) begin
         o_rd_data <= rd_nxt;
      end else begin
         o_rd_data <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* File: tb/reset_source_controller_sva.sv */
// checker: port-level assertions for the reset source controller
// assumes one core clock and an active-high power-on reset
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller_sva (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rd_data,
   input wire logic i_rst_pin_n,
   input wire logic o_rst_pin_out,
   input wire logic o_rst_pin_oe,
   input wire logic i_flash_fault,
   input wire logic i_flash_program,
   input wire logic o_sys_reset,
   input wire logic o_supply_on,
   input wire logic o_supply_high
);
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);
   chk_pin_drive_low: assert property (o_rst_pin_oe |-> o_sys_reset && !o_rst_pin_out)
      else $error("pin driven outside reset");
   chk_soft_no_pin: assert property (i_wr && i_addr == 8'hef && i_wr_data[4] && !o_sys_reset
      |=> !o_rst_pin_oe [*8])
      else $error("soft reset drove the pin");
   chk_soft_force_reset: assert property (i_wr && i_addr == 8'hef && i_wr_data[4] && !o_sys_reset
      |-> ##2 o_sys_reset)
      else $error("soft write gave no reset");
   chk_pin_low_reset: assert property (!i_rst_pin_n [*5] |-> o_sys_reset)
      else $error("low pin gave no reset");
   chk_flash_fault_reset: assert property (i_flash_fault && !o_sys_reset |-> ##[1:2] o_sys_reset)
      else $error("flash fault gave no reset");
   chk_flash_off_reset: assert property (i_flash_program && !o_supply_on && !o_sys_reset
      |-> ##[1:2] o_sys_reset)
      else $error("program with monitor off gave no reset");
   chk_supply_read_map: assert property (i_rd && i_addr == 8'hff && !o_sys_reset
      |=> o_rd_data[4:0] == 5'h00 && o_rd_data[7] == o_supply_on
      && o_rd_data[5] == o_supply_high)
      else $error("supply control read wrong");
   chk_supply_write: assert property (i_wr && i_addr == 8'hff && !o_sys_reset
      |=> o_supply_on == $past(i_wr_data[7]) && o_supply_high == $past(i_wr_data[5]))
      else $error("supply control write lost");
   chk_monitor_kept: assert property (!(i_wr && i_addr == 8'hff) |=> $stable(o_supply_on))
      else $error("monitor state changed without write");
endmodule
bind reset_source_controller reset_source_controller_sva chk_u (.i_core_clk(i_core_clk),
   .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
   .o_rd_data(o_rd_data), .i_rst_pin_n(i_rst_pin_n), .o_rst_pin_out(o_rst_pin_out),
   .o_rst_pin_oe(o_rst_pin_oe), .i_flash_fault(i_flash_fault),
   .i_flash_program(i_flash_program), .o_sys_reset(o_sys_reset), .o_supply_on(o_supply_on),
   .o_supply_high(o_supply_high));
`default_nettype wire

/* File: tb/ext_reset_driver.sv */
// external reset circuitry: pulls the reset pin low for a requested time
// assumes an open-drain pin with a pull-up, so the released level is high
`timescale 1ns/1ps
`default_nettype none
module ext_reset_driver (
   input wire logic i_core_clk,
   input wire logic i_go,
   input wire logic [7:0] i_len,
   output logic o_pull_n
);
   logic [7:0] cnt_r = 8'h00;
   always @(posedge i_core_clk) begin
      if (i_go)
         cnt_r <= i_len;
      else if (cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end
   assign o_pull_n = (cnt_r == 8'h00);
endmodule
`default_nettype wire

/* File: tb/reset_source_controller_tb_top.sv */
// bench: register and reset-cause model compared with the controller
// assumes a 20 MHz core clock and the external reset driver on the pin
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller_tb_top;
   logic clk, rst, wr, rd, rmw, sup, cmp, alarm, oscf, probe, ff, fp, go, run, m_sel, m_on, m_high;
   logic [7:0] addr, wd, len, lfsr, m_en, m_cause;
   logic [7:0] en_tab [7] = '{8'h22, 8'h82, 8'h82, 8'h06, 8'h02, 8'h02, 8'h02};
   logic [7:0] cause_tab [7] = '{8'h20, 8'h80, 8'h80, 8'h04, 8'h40, 8'h08, 8'h01};
   wire logic [7:0] rdd;
   wire logic pin_out, oe, sysr, son, shigh, pull_n;
   wire logic pin_n = pull_n & ~(oe & ~pin_out);
   integer error_cnt, checked, i;
   reset_source_controller #(.WD_LIMIT(16'h0010)) dut_u (.i_core_clk(clk), .i_sys_rst(rst),
      .i_addr(addr), .i_wr_data(wd), .i_wr(wr), .i_rd(rd), .i_rd_rmw(rmw), .o_rd_data(rdd),
      .i_rst_pin_n(pin_n), .o_rst_pin_out(pin_out), .o_rst_pin_oe(oe), .i_supply_above(sup),
      .i_cmp_below(cmp), .i_rtc_alarm(alarm), .i_rtc_osc_fail(oscf), .i_clk_probe(probe),
      .i_flash_fault(ff), .i_flash_program(fp), .o_sys_reset(sysr), .o_supply_on(son),
      .o_supply_high(shigh));
   ext_reset_driver drv_u (.i_core_clk(clk), .i_go(go), .i_len(len), .o_pull_n(pull_n));
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task final_report;
      $display("errors %0d of %0d checks", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] seen, exp);
      checked = checked + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wr8(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      if (a == 8'hef) begin
         m_sel = d[1];
         m_en = d & 8'ha4;
      end
      if (a == 8'hff) begin
         m_on = d[7];
         m_high = d[5];
      end
   endtask
   task rd8(input string nm, input logic [7:0] a, input logic r, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      rmw <= r;
      @(posedge clk);
      rd <= 1'b0;
      rmw <= 1'b0;
      #1;
      chk(nm, rdd, exp);
   endtask
   task wait_lvl(input logic v);
      integer n;
      for (n = 0; n < 3000 && sysr !== v; n++) begin
         @(posedge clk);
         #1;
      end
      if (sysr !== v) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED reset level exp %h seen %h", v, sysr);
         final_report;
      end
   endtask
   task settle(input logic [7:0] c);
      wait_lvl(1'b1);
      chk("pin drive", {6'h00, pin_out, oe}, {7'h00, c == 8'h02});
      @(posedge clk);
      cmp <= 1'b0;
      alarm <= 1'b0;
      oscf <= 1'b0;
      ff <= 1'b0;
      fp <= 1'b0;
      go <= 1'b0;
      run <= 1'b1;
      sup <= 1'b1;
      wait_lvl(1'b0);
      m_en = 8'h00;
      m_high = 1'b0;
      m_cause = c;
      lfsr = nxt(lfsr);
      rd8("cause", 8'hef, 1'b0, c);
      rd8("enables", 8'hef, 1'b1, m_en | {6'h00, m_sel, 1'b0});
      rd8("supply", 8'hff, 1'b0, {m_on, sup, m_high, 5'h00});
      chk("supply pins", {6'h00, son, shigh}, {6'h00, m_on, m_high});
      rd8("watchdog", 8'hd8, 1'b0, 8'h40);
      wr8(8'hd8, 8'h00);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
      if (run)
         probe <= ~probe;
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      rmw = 1'b0;
      addr = 8'h00;
      wd = 8'h00;
      sup = 1'b1;
      cmp = 1'b0;
      alarm = 1'b0;
      oscf = 1'b0;
      probe = 1'b0;
      ff = 1'b0;
      fp = 1'b0;
      go = 1'b0;
      len = 8'h00;
      run = 1'b1;
      lfsr = 8'h1f;
      error_cnt = 0;
      checked = 0;
      m_sel = 1'b1;
      m_on = 1'b1;
      m_high = 1'b0;
      m_en = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      settle(8'h02);
      wr8(8'hff, {3'b011, lfsr[4:0]});
      rd8("supply", 8'hff, 1'b0, {m_on, sup, m_high, 5'h00});
      @(posedge clk);
      fp <= 1'b1;
      settle(8'h40);
      wr8(8'hff, 8'ha0);
      wr8(8'hef, 8'h12);
      settle(8'h10);
      for (i = 0; i < 7; i++) begin
         wr8(8'hef, en_tab[i]);
         rd8("enables", 8'hef, 1'b1, m_en | {6'h00, m_sel, 1'b0});
         rd8("flags", 8'hef, 1'b0, m_cause);
         @(posedge clk);
         case (i)
            0: cmp <= 1'b1;
            1: alarm <= 1'b1;
            2: oscf <= 1'b1;
            3: run <= 1'b0;
            4: ff <= 1'b1;
            5: begin
               wr8(8'hd8, 8'h40);
               repeat (150) @(posedge clk);
               wr8(8'hd8, 8'h41);
               repeat (150) @(posedge clk);
               chk("kick", {7'h00, sysr}, 8'h00);
            end
            default: begin
               len <= 8'h08 + {4'h0, lfsr[3:0]};
               go <= 1'b1;
            end
         endcase
         settle(cause_tab[i]);
      end
      wr8(8'hef, 8'h00);
      sup <= 1'b0;
      repeat (4) @(posedge clk);
      rd8("supply", 8'hff, 1'b0, {m_on, sup, m_high, 5'h00});
      chk("quiet", {7'h00, sysr}, 8'h00);
      wr8(8'hef, 8'h02);
      settle(8'h02);
      final_report;
   end
endmodule
`default_nettype wire
